// ==== hdl/pas_phy_special.sv ====
// one phy special control/status register: control bits plus live status
`timescale 1ns/1ps
`default_nettype none
module pas_phy_special (
  input wire logic clock,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [15:0] wdata,
  input wire pas_pkg::pas_phy_stat_t stat_sync,
  output pas_pkg::pas_special_t ctrl,
  output logic [15:0] rdata
);
  import pas_pkg::*;

  typedef struct packed {
    pas_special_t ctrl;
  } pas_spc_state_t;

  pas_spc_state_t st_r;
  pas_spc_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (wr_en) begin
      st_nxt.ctrl.force_link = wdata[POS_FORCE_LINK];
      st_nxt.ctrl.eee_off = wdata[POS_EEE_OFF];
      st_nxt.ctrl.near_loop = wdata[POS_NEAR_LOOP];
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      st_r.ctrl <= SPECIAL_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ctrl = st_r.ctrl;

  // bit 0 is documented writable but does nothing; kept reading zero
  always_comb begin
    rdata = 16'h0000;
    rdata[POS_POLARITY] = stat_sync.polarity_rev;
    rdata[POS_MDIX] = stat_sync.mdix;
    rdata[POS_FORCE_LINK] = st_r.ctrl.force_link;
    rdata[POS_EEE_OFF] = st_r.ctrl.eee_off;
    rdata[POS_NEAR_LOOP] = st_r.ctrl.near_loop;
  end

  a_ctrl_write: assert property (@(posedge clock) disable iff (!rstn)
    wr_en |=> ctrl == $past({wdata[POS_FORCE_LINK], wdata[POS_EEE_OFF], wdata[POS_NEAR_LOOP]}))
    else $error("special control bits did not take the write");
  a_ctrl_hold: assert property (@(posedge clock) disable iff (!rstn)
    !wr_en |=> $stable(ctrl))
    else $error("special control changed without a write");
  a_status_ro: assert property (@(posedge clock) disable iff (!rstn)
    rdata[POS_MDIX] == stat_sync.mdix && rdata[15:6] == 10'h000)
    else $error("special status bits wrong");
endmodule : pas_phy_special
`default_nettype wire

// ==== hdl/pas_pkg.sv ====
// package: offsets, field positions and reset values of the phy autoneg/special register bank
package pas_pkg;
  localparam logic [11:0] OFS_ADVERTISE = 12'h060;
  localparam logic [11:0] OFS_PARTNER = 12'h062;
  localparam logic [11:0] OFS_PHY1_SPECIAL = 12'h066;
  localparam logic [11:0] OFS_PHY2_SPECIAL = 12'h06a;

  localparam int POS_PAUSE = 10;
  localparam int POS_ABIL_HI = 8;
  localparam int POS_ABIL_LO = 5;
  localparam int POS_POLARITY = 5;
  localparam int POS_MDIX = 4;
  localparam int POS_FORCE_LINK = 3;
  localparam int POS_EEE_OFF = 2;
  localparam int POS_NEAR_LOOP = 1;

  localparam logic [4:0] SELECTOR_VAL = 5'h01;
  localparam logic [4:0] ADV_RESET = 5'h1f;
  localparam logic [4:0] PARTNER_RESET = 5'h00;
  localparam logic [2:0] SPECIAL_RESET = 3'h2;

  // pause at bit 4, then 100fd, 100hd, 10fd, 10hd down to bit 0
  typedef struct packed {
    logic pause;
    logic [3:0] abil;
  } pas_abil_t;

  typedef struct packed {
    logic force_link;
    logic eee_off;
    logic near_loop;
  } pas_special_t;

  typedef struct packed {
    logic polarity_rev;
    logic mdix;
  } pas_phy_stat_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [15:0] wdata;
  } pas_req_t;
endpackage : pas_pkg

// ==== hdl/pas_regs.sv ====
// register bank: port 2 advertisement, partner ability and both phy special registers
//
// Summary of operation
// - advertise pause bit 10, rw, reset 1
// - bits 8..5 speed/duplex advertise, rw, reset 1
// - next page, fault, reserved zero; selector 0x01
// - partner ability read-only, cleared at reset
// - partner bits mirror port 2 status
// - partner np/ack/fault zero; low bits 0x01
// - bit 5 reports reversed receive polarity
// - bit 4 reports mdi or mdi-x
// - bit 3 forces link pass, reset 0
// - bit 2 disables 10base-te, reset 1
// - bit 1 enables near-end loopback, reset 0
`timescale 1ns/1ps
`default_nettype none
module pas_regs (
  input wire logic clock,
  input wire logic rstn,
  input wire pas_pkg::pas_req_t req,
  output logic [15:0] rdata,
  output logic rvalid,
  input wire logic cr4_wr,
  input wire logic [4:0] cr4_wdata,
  output pas_pkg::pas_abil_t port2_control_four,
  input wire pas_pkg::pas_abil_t partner_abil_in,
  input wire logic partner_abil_load,
  output pas_pkg::pas_abil_t port2_status_reg,
  input wire pas_pkg::pas_phy_stat_t phy1_stat_in,
  input wire pas_pkg::pas_phy_stat_t phy2_stat_in,
  output pas_pkg::pas_special_t phy1_ctrl,
  output pas_pkg::pas_special_t phy2_ctrl
);
  import pas_pkg::*;

  typedef struct packed {
    pas_abil_t adv;
    pas_abil_t partner;
    pas_phy_stat_t p1_s1;
    pas_phy_stat_t p1_s2;
    pas_phy_stat_t p2_s1;
    pas_phy_stat_t p2_s2;
    logic [15:0] rdata;
    logic rvalid;
  } pas_state_t;

  pas_state_t st_r;
  pas_state_t st_nxt;
  logic [15:0] p1_rdata;
  logic [15:0] p2_rdata;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic [15:0] pack_abil(input pas_abil_t v);
    pack_abil = 16'h0000;
    pack_abil[POS_PAUSE] = v.pause;
    pack_abil[POS_ABIL_HI:POS_ABIL_LO] = v.abil;
    pack_abil[4:0] = SELECTOR_VAL;
  endfunction : pack_abil

  always_comb begin
    st_nxt = st_r;
    // status pins come from the phy analog domain; two flops before use
    st_nxt.p1_s1 = phy1_stat_in;
    st_nxt.p1_s2 = st_r.p1_s1;
    st_nxt.p2_s1 = phy2_stat_in;
    st_nxt.p2_s2 = st_r.p2_s1;
    // host write wins over control-four write in the same cycle: last writer
    if (cr4_wr) begin
      st_nxt.adv = cr4_wdata;
    end
    if (req.wr && hit(req.addr, OFS_ADVERTISE)) begin
      st_nxt.adv.pause = req.wdata[POS_PAUSE];
      st_nxt.adv.abil = req.wdata[POS_ABIL_HI:POS_ABIL_LO];
    end
    if (partner_abil_load) begin
      st_nxt.partner = partner_abil_in;
    end
    st_nxt.rvalid = req.rd;
    st_nxt.rdata = 16'h0000;
    if (req.rd) begin
      if (hit(req.addr, OFS_ADVERTISE)) begin
        st_nxt.rdata = pack_abil(st_r.adv);
      end else if (hit(req.addr, OFS_PARTNER)) begin
        st_nxt.rdata = pack_abil(st_r.partner);
      end else if (hit(req.addr, OFS_PHY1_SPECIAL)) begin
        st_nxt.rdata = p1_rdata;
      end else if (hit(req.addr, OFS_PHY2_SPECIAL)) begin
        st_nxt.rdata = p2_rdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      st_r.adv <= ADV_RESET;
      st_r.partner <= PARTNER_RESET;
      st_r.p1_s1 <= 2'h0;
      st_r.p1_s2 <= 2'h0;
      st_r.p2_s1 <= 2'h0;
      st_r.p2_s2 <= 2'h0;
      st_r.rdata <= 16'h0000;
      st_r.rvalid <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  pas_phy_special u_phy1 (
    .clock(clock),
    .rstn(rstn),
    .wr_en(req.wr && hit(req.addr, OFS_PHY1_SPECIAL)),
    .wdata(req.wdata),
    .stat_sync(st_r.p1_s2),
    .ctrl(phy1_ctrl),
    .rdata(p1_rdata)
  );

  pas_phy_special u_phy2 (
    .clock(clock),
    .rstn(rstn),
    .wr_en(req.wr && hit(req.addr, OFS_PHY2_SPECIAL)),
    .wdata(req.wdata),
    .stat_sync(st_r.p2_s2),
    .ctrl(phy2_ctrl),
    .rdata(p2_rdata)
  );

  assign port2_control_four = st_r.adv;
  assign port2_status_reg = st_r.partner;
  assign rdata = st_r.rdata;
  assign rvalid = st_r.rvalid;

  a_adv_write: assert property (@(posedge clock) disable iff (!rstn)
    req.wr && hit(req.addr, OFS_ADVERTISE) |=>
      port2_control_four == $past({req.wdata[POS_PAUSE], req.wdata[8:5]}))
    else $error("advertise write not seen in control four");
  a_adv_read: assert property (@(posedge clock) disable iff (!rstn)
    req.rd && hit(req.addr, OFS_ADVERTISE) && !cr4_wr && !req.wr |=>
      rdata == {5'h00, port2_control_four.pause, 1'b0, port2_control_four.abil, 5'h01})
    else $error("advertise readback wrong");
  a_partner_mirror: assert property (@(posedge clock) disable iff (!rstn)
    req.rd && hit(req.addr, OFS_PARTNER) && !partner_abil_load |=>
      rdata[10] == port2_status_reg.pause && rdata[8:5] == port2_status_reg.abil)
    else $error("partner bits differ from status");
  a_partner_fixed: assert property (@(posedge clock) disable iff (!rstn)
    $past(req.rd) && $past(hit(req.addr, OFS_PARTNER)) |->
      rdata[15:11] == 5'h00 && rdata[9] == 1'b0 && rdata[4:0] == 5'h01)
    else $error("partner fixed bits wrong");
  a_partner_load: assert property (@(posedge clock) disable iff (!rstn)
    partner_abil_load |=> port2_status_reg == $past(partner_abil_in))
    else $error("partner ability not loaded");
  // raw pin seen two flops plus one read cycle earlier
  a_polarity_sync: assert property (@(posedge clock) disable iff (!rstn)
    req.rd && hit(req.addr, OFS_PHY2_SPECIAL) |=>
      rdata[POS_POLARITY] == $past(phy2_stat_in.polarity_rev, 3))
    else $error("polarity status readback wrong");
  a_phy1_loop: assert property (@(posedge clock) disable iff (!rstn)
    req.wr && hit(req.addr, OFS_PHY1_SPECIAL) |=>
      phy1_ctrl.near_loop == $past(req.wdata[POS_NEAR_LOOP]))
    else $error("phy1 loopback write lost");
  a_phy_isolate: assert property (@(posedge clock) disable iff (!rstn)
    req.wr && hit(req.addr, OFS_PHY1_SPECIAL) |=>
      $stable(phy2_ctrl))
    else $error("phy1 write disturbed phy2 control");
  a_phy2_eee: assert property (@(posedge clock) disable iff (!rstn)
    req.wr && hit(req.addr, OFS_PHY2_SPECIAL) |=>
      phy2_ctrl.eee_off == $past(req.wdata[POS_EEE_OFF]))
    else $error("phy2 eee write lost");
  a_unmapped_zero: assert property (@(posedge clock) disable iff (!rstn)
    req.rd && !hit(req.addr, OFS_ADVERTISE) && !hit(req.addr, OFS_PARTNER)
      && !hit(req.addr, OFS_PHY1_SPECIAL) && !hit(req.addr, OFS_PHY2_SPECIAL)
      |=> rvalid && rdata == 16'h0000)
    else $error("unmapped read not zero");

  a_reset_values: assert property (@(posedge clock)
    !rstn |=> port2_control_four == ADV_RESET && port2_status_reg == PARTNER_RESET
      && phy1_ctrl == SPECIAL_RESET && phy2_ctrl == SPECIAL_RESET && !rvalid)
    else $error("register reset values wrong");
  a_adv_fixed: assert property (@(posedge clock) disable iff (!rstn)
    $past(req.rd) && $past(hit(req.addr, OFS_ADVERTISE)) |->
      rdata[15:11] == 5'h00 && rdata[9] == 1'b0 && rdata[4:0] == SELECTOR_VAL)
    else $error("advertise fixed bits wrong");
  a_cr4_alias: assert property (@(posedge clock) disable iff (!rstn)
    cr4_wr && !(req.wr && hit(req.addr, OFS_ADVERTISE)) |=>
      port2_control_four == $past(cr4_wdata))
    else $error("control four write not seen in advertise");
  a_adv_hold: assert property (@(posedge clock) disable iff (!rstn)
    !cr4_wr && !(req.wr && hit(req.addr, OFS_ADVERTISE)) |=>
      $stable(port2_control_four))
    else $error("advertise bits changed without a write");
  a_partner_hold: assert property (@(posedge clock) disable iff (!rstn)
    !partner_abil_load |=> $stable(port2_status_reg))
    else $error("partner ability changed without a load");
  a_read_latency: assert property (@(posedge clock) disable iff (!rstn)
    req.rd |=> rvalid)
    else $error("read answer missing");
  a_idle_quiet: assert property (@(posedge clock) disable iff (!rstn)
    !req.rd |=> !rvalid && rdata == 16'h0000)
    else $error("read data shown without a read");
  a_phy1_force: assert property (@(posedge clock) disable iff (!rstn)
    req.wr && hit(req.addr, OFS_PHY1_SPECIAL) |=>
      phy1_ctrl.force_link == $past(req.wdata[POS_FORCE_LINK]))
    else $error("phy1 force link write lost");
  a_phy2_loop: assert property (@(posedge clock) disable iff (!rstn)
    req.wr && hit(req.addr, OFS_PHY2_SPECIAL) |=>
      phy2_ctrl.near_loop == $past(req.wdata[POS_NEAR_LOOP]))
    else $error("phy2 loopback write lost");
  a_phy1_eee: assert property (@(posedge clock) disable iff (!rstn)
    req.wr && hit(req.addr, OFS_PHY1_SPECIAL) |=>
      phy1_ctrl.eee_off == $past(req.wdata[POS_EEE_OFF]))
    else $error("phy1 eee write lost");
  a_status_sync: assert property (@(posedge clock) disable iff (!rstn)
    st_r.p1_s2 == $past(phy1_stat_in, 2))
    else $error("phy1 status synchroniser delay wrong");
  a_special_reserved: assert property (@(posedge clock) disable iff (!rstn)
    $past(req.rd) && ($past(hit(req.addr, OFS_PHY1_SPECIAL))
      || $past(hit(req.addr, OFS_PHY2_SPECIAL))) |-> rdata[15:6] == 10'h000 && !rdata[0])
    else $error("special reserved bits not zero");
endmodule : pas_regs
`default_nettype wire

// ==== tb/pas_link_partner.sv ====
// tb: remote partner model feeding partner ability and raw phy line status
`timescale 1ns/1ps
`default_nettype none
module pas_link_partner #(parameter int LAG = 2) (
  input wire logic clock,
  input wire logic send,
  input wire pas_pkg::pas_abil_t abil_cmd,
  input wire logic [3:0] stat_cmd,
  output pas_pkg::pas_abil_t partner_abil_in,
  output logic partner_abil_load,
  output pas_pkg::pas_phy_stat_t phy1_stat_in,
  output pas_pkg::pas_phy_stat_t phy2_stat_in
);
  import pas_pkg::*;
  initial partner_abil_in = '0;
  initial partner_abil_load = 1'b0;
  // line status is an async level, not tied to clock
  assign phy1_stat_in = stat_cmd[3:2];
  assign phy2_stat_in = stat_cmd[1:0];
  always @(posedge clock) begin
    if (send) begin
      repeat (LAG) @(posedge clock);
      #1;
      partner_abil_in = abil_cmd;
      partner_abil_load = 1'b1;
      @(posedge clock);
      #1;
      partner_abil_load = 1'b0;
      // bus released: show junk so a late capture is caught
      partner_abil_in = ~abil_cmd;
    end
  end
endmodule : pas_link_partner
`default_nettype wire

// ==== tb/tb_phy_autoneg_special_regs.sv ====
// tb: self-checking bench for the autoneg and phy special register bank
`timescale 1ns/1ps
`default_nettype none
module tb_phy_autoneg_special_regs;
  import pas_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  pas_req_t req = '0;
  logic [15:0] rdata;
  logic rvalid;
  logic cr4_wr = 1'b0;
  logic [4:0] cr4_wdata = '0;
  pas_abil_t ctl4, sreg, pin, abil_cmd = '0;
  logic pload;
  logic send = 1'b0;
  logic [3:0] stat_cmd = '0;
  pas_phy_stat_t s1, s2;
  pas_special_t c1, c2;
  logic [15:0] expq[$];
  logic [15:0] d;
  int fail_count = 0;
  int compares = 0;
  always #4 clock = ~clock;
  pas_regs u_dut (.clock(clock), .rstn(rstn), .req(req), .rdata(rdata), .rvalid(rvalid),
    .cr4_wr(cr4_wr), .cr4_wdata(cr4_wdata), .port2_control_four(ctl4),
    .partner_abil_in(pin), .partner_abil_load(pload), .port2_status_reg(sreg),
    .phy1_stat_in(s1), .phy2_stat_in(s2), .phy1_ctrl(c1), .phy2_ctrl(c2));
  pas_link_partner #(.LAG(2)) u_partner (.clock(clock), .send(send), .abil_cmd(abil_cmd),
    .stat_cmd(stat_cmd), .partner_abil_in(pin), .partner_abil_load(pload),
    .phy1_stat_in(s1), .phy2_stat_in(s2));
  task automatic chk_rd(logic [15:0] e, logic [15:0] s);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR rdata expected %h seen %h", e, s);
    end
  endtask : chk_rd
  task automatic chk_lvl(string what, logic [4:0] e, logic [4:0] s);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, e, s);
    end
  endtask : chk_lvl
  task automatic conclude;
    if (expq.size() != 0) fail_count++;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  // each call spans one cycle, so calls run back to back
  task automatic rd(logic [11:0] a, logic [15:0] e);
    req.wr = 1'b0;
    req.rd = 1'b1;
    req.addr = a;
    expq.push_back(e);
    @(posedge clock);
    #1;
  endtask : rd
  task automatic wr(logic [11:0] a, logic [15:0] v);
    req.rd = 1'b0;
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = v;
    @(posedge clock);
    #1;
  endtask : wr
  task automatic idle;
    req.rd = 1'b0;
    req.wr = 1'b0;
    @(posedge clock);
    #1;
  endtask : idle
  // negedge sampling keeps clear of the launch edge
  always @(negedge clock) begin
    if (rvalid === 1'b1) begin
      if (expq.size() == 0) chk_rd(16'hxxxx, rdata);
      else chk_rd(expq.pop_front(), rdata);
    end
  end
  initial begin
    #20000;
    fail_count++;
    conclude();
  end
  initial begin
    void'($urandom(8));
    repeat (4) @(posedge clock);
    #1;
    rstn = 1'b1;
    chk_lvl("port2_control_four", 5'h1f, ctl4);
    chk_lvl("phy1_ctrl", 5'h02, {2'b00, c1});
    chk_lvl("port2_status_reg", 5'h00, sreg);
    rd(OFS_ADVERTISE, 16'h05e1);
    rd(OFS_PARTNER, 16'h0001);
    rd(OFS_PHY1_SPECIAL, 16'h0004);
    rd(OFS_PHY2_SPECIAL, 16'h0004);
    rd(12'h064, 16'h0000);
    wr(OFS_PARTNER, 16'hffff);
    wr(12'h064, 16'hffff);
    rd(OFS_PARTNER, 16'h0001);
    wr(OFS_ADVERTISE, 16'hffff);
    rd(OFS_ADVERTISE, 16'h05e1);
    wr(OFS_ADVERTISE, 16'h0000);
    rd(OFS_ADVERTISE, 16'h0001);
    for (int i = 0; i < 8; i++) begin
      d = 16'($urandom);
      wr(OFS_ADVERTISE, d);
      rd(OFS_ADVERTISE, {5'h00, d[10], 1'b0, d[8:5], SELECTOR_VAL});
      wr(OFS_PHY1_SPECIAL, d);
      wr(OFS_PHY2_SPECIAL, ~d);
      stat_cmd = d[3:0];
      idle();
      chk_lvl("port2_control_four", {d[10], d[8:5]}, ctl4);
      chk_lvl("phy1_ctrl", {2'b00, d[3:1]}, {2'b00, c1});
      chk_lvl("phy2_ctrl", {2'b00, ~d[3:1]}, {2'b00, c2});
      repeat (2) idle();
      rd(OFS_PHY1_SPECIAL, {10'h000, d[3], d[2], d[3:1], 1'b0});
      rd(OFS_PHY2_SPECIAL, {10'h000, d[1], d[0], ~d[3:1], 1'b0});
      cr4_wr = 1'b1;
      cr4_wdata = d[15:11];
      idle();
      cr4_wr = 1'b0;
      rd(OFS_ADVERTISE, {5'h00, d[15], 1'b0, d[14:11], SELECTOR_VAL});
      abil_cmd = d[12:8];
      send = 1'b1;
      idle();
      send = 1'b0;
      repeat (4) idle();
      rd(OFS_PARTNER, {5'h00, d[12], 1'b0, d[11:8], 5'h01});
      idle();
      chk_lvl("port2_status_reg", d[12:8], sreg);
    end
    cr4_wr = 1'b1;
    cr4_wdata = 5'h00;
    wr(OFS_ADVERTISE, 16'hffff);
    cr4_wr = 1'b0;
    rd(OFS_ADVERTISE, 16'h05e1);
    repeat (2) idle();
    conclude();
  end
endmodule : tb_phy_autoneg_special_regs
`default_nettype wire
